//--- xy_pkg.sv
// Shared types and constants for the dual data space access block.
// Assumes a 16-bit core whose execution unit issues word addresses.
package xy_pkg;

   // ======================================================================
   // Widths and build constants
   // ======================================================================
   localparam int ADDR_W = 14;
   localparam int DATA_W = 16;
   localparam logic [13:0] XY_SPLIT_RST = 14'h2000;
   localparam logic [13:0] MOD_START_RST = 14'h0000;
   localparam logic [13:0] MOD_END_RST = 14'h3FFF;

   // Address mode of one generator request.
   typedef enum logic [1:0] {
      AM_LINEAR,
      AM_MODULO,
      AM_BITREV
   } addr_mode_e;

   // One address generator request from the execution unit.
   typedef struct packed {
      logic valid;
      logic [13:0] base;
      logic [13:0] offset;
      addr_mode_e mode;
      logic [13:0] mod_start;
      logic [13:0] mod_end;
   } agen_req_s;

   // One registered read answer.
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } rd_ans_s;

endpackage

//--- xy_ram.sv
// Two-read-port, one-write-port data memory with registered read data.
// Assumes the caller never needs write-through on the same cycle.
`timescale 1ns/1ps

module xy_ram #(
   parameter int AW = 14,
   parameter int DW = 16
) (
   // Clock.
   input wire logic clk,
   // Read port A and B.
   input wire logic [AW-1:0] a_addr,
   output logic [DW-1:0] a_data,
   input wire logic [AW-1:0] b_addr,
   output logic [DW-1:0] b_data,
   // Write port.
   input wire logic w_en,
   input wire logic [AW-1:0] w_addr,
   input wire logic [DW-1:0] w_data
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ======================================================================
   // Storage
   // ======================================================================
   // Both read ports sample every cycle, so no arbitration is ever needed.
   always_ff @(posedge clk) begin
      if (w_en) begin
         mem[w_addr] <= w_data;
      end
      a_data <= mem[a_addr];
      b_data <= mem[b_addr];
   end

endmodule

//--- xy_access.sv
// Dual data space access: two address generators, X and Y read paths.
// Assumes the execution unit holds requests for one cycle each.
`timescale 1ns/1ps

// What this block does
// - Data RAM split into X and Y spaces.
// - Two independent address generators, separate data paths.
// - X space serves all instructions, all modes.
// - X space has separate read and write buses.
// - Combined-space reads return on X read bus.
// - X read bus carries MAC X prefetch.
// - Y read only with MAC class instructions.
// - Modulo addressing on both spaces.
// - Bit-reverse only on writes, in either space.
// - Reduced build drops modulo and bit-reverse.
// - All writes decoded over combined space.
// - X/Y boundary fixed per build.
module xy_access #(
   parameter logic [13:0] XY_SPLIT = xy_pkg::XY_SPLIT_RST,
   parameter bit HAS_ADV_MODES = 1'b1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Read request, X generator, and MAC class flag.
   input wire xy_pkg::agen_req_s x_rd_req,
   input wire logic mac_op,
   // Read request, Y generator.
   input wire xy_pkg::agen_req_s y_rd_req,
   // Write request.
   input wire xy_pkg::agen_req_s wr_req,
   input wire logic [15:0] wr_data,
   // Read answers.
   output xy_pkg::rd_ans_s x_rd_ans,
   output xy_pkg::rd_ans_s y_rd_ans,
   // Status.
   output logic y_rd_refused,
   output logic wr_in_y
);

   // ======================================================================
   // Address generation
   // ======================================================================
   // Effective address for a request; reduced build falls back to linear.
   function automatic logic [13:0] agen(input xy_pkg::agen_req_s r,
                                        input logic allow_rev);
      logic [13:0] sum;
      logic [13:0] rev;
      sum = 14'(r.base + r.offset);
      for (int i = 0; i < 14; i++) begin
         rev[i] = r.offset[13-i];
      end
      agen = sum;
      if (HAS_ADV_MODES) begin
         if (r.mode == xy_pkg::AM_MODULO && sum > r.mod_end) begin
            agen = 14'(r.mod_start + (sum - r.mod_end) - 14'h0001);
         end else if (r.mode == xy_pkg::AM_BITREV && allow_rev) begin
            agen = 14'(r.base + rev);
         end
      end
   endfunction

   // Space decode, shared by the Y read gate, the write flag and the checks.
   // The split is a build parameter, so software has no way to move it.
   function automatic logic in_y_space(input logic [13:0] a);
      in_y_space = (a >= XY_SPLIT);
   endfunction

   // ======================================================================
   // State
   // ======================================================================
   // All state of the block: two answer strobes and two status flags.
   // Read data are not copied here, since they already leave a register.
   typedef struct packed {
      logic x_ok;
      logic y_ok;
      logic refused;
      logic in_y;
   } state_s;

   state_s s_q;
   state_s s_d;
   logic [13:0] x_addr;
   logic [13:0] y_addr;
   logic [13:0] w_addr;
   logic y_go;
   logic [15:0] x_dat;
   logic [15:0] y_dat;

   // Generators run side by side; Y is used only with a MAC op.
   // Neither lane waits for the other, so a dual fetch never stalls.
   always_comb begin
      x_addr = agen(x_rd_req, 1'b0);
      y_addr = agen(y_rd_req, 1'b0);
      w_addr = agen(wr_req, 1'b1);
      y_go = y_rd_req.valid && mac_op && in_y_space(y_addr);
   end

   // ======================================================================
   // Memory
   // ======================================================================
   // One unified array keeps the boundary a build constant only.
   // The write port is a bus of its own, apart from both read ports.
   xy_ram #(.AW(14), .DW(16)) u_ram (
      .clk(clk),
      .a_addr(x_addr),
      .a_data(x_dat),
      .b_addr(y_addr),
      .b_data(y_dat),
      .w_en(wr_req.valid),
      .w_addr(w_addr),
      .w_data(wr_data)
   );

   // ======================================================================
   // Next state and register
   // ======================================================================
   // Answers mark validity one cycle after the request.
   always_comb begin
      s_d = s_q;
      s_d.x_ok = x_rd_req.valid;
      s_d.y_ok = y_go;
      s_d.refused = y_rd_req.valid && !y_go;
      s_d.in_y = wr_req.valid && in_y_space(w_addr);
   end

   // State register with synchronous reset.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ======================================================================
   // Outputs
   // ======================================================================
   // Strobes and flags come from the state register and read data from the
   // memory's output register, so no gate stands before a port. Data seen
   // outside a valid cycle are stale and must be ignored by the user.
   always_comb begin
      x_rd_ans.valid = s_q.x_ok;
      x_rd_ans.data = x_dat;
      y_rd_ans.valid = s_q.y_ok;
      y_rd_ans.data = y_dat;
      y_rd_refused = s_q.refused;
      wr_in_y = s_q.in_y;
   end

   // ======================================================================
   // Checks
   // ======================================================================
   a_x_read_lat: assert property (
      @(posedge clk) disable iff (!resetn)
      x_rd_req.valid |=> x_rd_ans.valid)
      else $error("x read not answered next cycle");
   a_y_mac_only: assert property (
      @(posedge clk) disable iff (!resetn)
      y_rd_ans.valid |-> $past(mac_op))
      else $error("y read without mac op");
   a_dual_same: assert property (
      @(posedge clk) disable iff (!resetn)
      (x_rd_req.valid && y_go) |=> (x_rd_ans.valid && y_rd_ans.valid))
      else $error("dual read split over cycles");
   a_y_refuse: assert property (
      @(posedge clk) disable iff (!resetn)
      (y_rd_req.valid && !mac_op) |=> y_rd_refused)
      else $error("non-mac y read not refused");
   a_wr_split: assert property (
      @(posedge clk) disable iff (!resetn)
      wr_req.valid |=> (wr_in_y == ($past(w_addr) >= XY_SPLIT)))
      else $error("write decode wrong");
   a_lin_addr: assert property (
      @(posedge clk) disable iff (!resetn)
      (x_rd_req.mode == xy_pkg::AM_LINEAR) |->
      x_addr == 14'(x_rd_req.base + x_rd_req.offset))
      else $error("linear address wrong");
   a_no_rev_rd: assert property (
      @(posedge clk) disable iff (!resetn)
      (x_rd_req.mode == xy_pkg::AM_BITREV) |->
      x_addr == 14'(x_rd_req.base + x_rd_req.offset))
      else $error("bit reverse applied to read");
   a_mod_range: assert property (
      @(posedge clk) disable iff (!resetn)
      (HAS_ADV_MODES && y_rd_req.mode == xy_pkg::AM_MODULO &&
      14'(y_rd_req.base + y_rd_req.offset) > y_rd_req.mod_end) |->
      y_addr >= y_rd_req.mod_start)
      else $error("modulo wrap below start");
   // A MAC read that lands below the split is turned away, not served.
   a_y_split_gate: assert property (
      @(posedge clk) disable iff (!resetn)
      (y_rd_req.valid && mac_op && !in_y_space(y_addr)) |=>
      (y_rd_refused && !y_rd_ans.valid))
      else $error("y read below split served");
   a_y_mac_served: assert property (
      @(posedge clk) disable iff (!resetn)
      (y_rd_req.valid && mac_op && in_y_space(y_addr)) |=>
      (y_rd_ans.valid && !y_rd_refused))
      else $error("mac y read not served");
   a_wr_flag_idle: assert property (
      @(posedge clk) disable iff (!resetn)
      !wr_req.valid |=> !wr_in_y)
      else $error("write flag without write");
   a_x_idle: assert property (
      @(posedge clk) disable iff (!resetn)
      !x_rd_req.valid |=> !x_rd_ans.valid)
      else $error("x answer without request");
   // The reduced build must leave the write and Y addresses plainly linear.
   a_lite_linear: assert property (
      @(posedge clk) disable iff (!resetn)
      !HAS_ADV_MODES |->
      (w_addr == 14'(wr_req.base + wr_req.offset) &&
      y_addr == 14'(y_rd_req.base + y_rd_req.offset)))
      else $error("reduced build not linear");
   a_mod_range_x: assert property (
      @(posedge clk) disable iff (!resetn)
      (HAS_ADV_MODES && x_rd_req.mode == xy_pkg::AM_MODULO &&
      14'(x_rd_req.base + x_rd_req.offset) > x_rd_req.mod_end) |->
      x_addr >= x_rd_req.mod_start)
      else $error("x modulo wrap below start");
   c_dual: cover property (@(posedge clk) x_rd_ans.valid && y_rd_ans.valid);
   c_refuse: cover property (@(posedge clk) y_rd_refused);
   c_wr_y: cover property (@(posedge clk) wr_in_y);
   c_mod_y: cover property (@(posedge clk)
      y_go && y_rd_req.mode == xy_pkg::AM_MODULO);
   c_rev_wr: cover property (@(posedge clk)
      wr_req.valid && wr_req.mode == xy_pkg::AM_BITREV);

endmodule

//--- exec_model.sv
// Execution unit model: drives read and write requests into the block.
// Assumes callers enter issue just after a rising clock edge.
`timescale 1ns/1ps

module exec_model (
   // Clock.
   input wire logic clk,
   // Requests towards the access block.
   output xy_pkg::agen_req_s x_req,
   output xy_pkg::agen_req_s y_req,
   output xy_pkg::agen_req_s w_req,
   output logic [15:0] w_data,
   output logic mac
);
   // ==========================================================
   // Request driving
   // ==========================================================
   // Requests are replaced, never cleared, so back-to-back works.
   task automatic issue(input xy_pkg::agen_req_s x, y, w,
                        input logic [15:0] d, input logic m);
      x_req = x;
      y_req = y;
      w_req = w;
      w_data = d;
      mac = m;
      @(posedge clk);
      #1;
   endtask

   // Quiet bus at time zero.
   initial begin
      issue('0, '0, '0, 16'h0000, 1'b0);
   end
endmodule

//--- xy_access_tb.sv
// Self-checking bench for the dual data space access block.
// Assumes the block answers one cycle after each request.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module xy_access_tb;
   // ==========================================================
   // Signals
   // ==========================================================
   localparam logic [13:0] SPL = xy_pkg::XY_SPLIT_RST;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   xy_pkg::agen_req_s x_req, y_req, w_req, z;
   xy_pkg::rd_ans_s xa, ya;
   logic [15:0] w_data;
   logic mac, refused, in_y;
   xy_pkg::rd_ans_s lxa, lya;
   logic lrefused, lin_y;
   logic [13:0] a0, a1;
   logic [15:0] mem [logic [13:0]];

   xy_access DUT (.clk(clk), .resetn(resetn), .x_rd_req(x_req),
      .mac_op(mac), .y_rd_req(y_req), .wr_req(w_req), .wr_data(w_data),
      .x_rd_ans(xa), .y_rd_ans(ya), .y_rd_refused(refused),
      .wr_in_y(in_y));
   // Reduced build on the same requests; its memory is not modelled.
   xy_access #(.HAS_ADV_MODES(1'b0)) LITE (.clk(clk), .resetn(resetn),
      .x_rd_req(x_req), .mac_op(mac), .y_rd_req(y_req), .wr_req(w_req),
      .wr_data(w_data), .x_rd_ans(lxa), .y_rd_ans(lya),
      .y_rd_refused(lrefused), .wr_in_y(lin_y));
   exec_model EXU (.clk(clk), .x_req(x_req), .y_req(y_req),
      .w_req(w_req), .w_data(w_data), .mac(mac));

   // 250 MHz clock.
   always #2 clk = ~clk;

   // ==========================================================
   // Expectation helpers
   // ==========================================================
   // Reads never bit-reverse, so wr gates that mode.
   function automatic logic [13:0] eff(xy_pkg::agen_req_s r, bit wr);
      logic [13:0] s;
      logic [13:0] rv;
      s = r.base + r.offset;
      for (int i = 0; i < 14; i++) rv[i] = r.offset[13-i];
      if (r.mode == xy_pkg::AM_MODULO && s > r.mod_end)
         s = r.mod_start + (s - r.mod_end) - 14'h0001;
      if (r.mode == xy_pkg::AM_BITREV && wr) s = r.base + rv;
      return s;
   endfunction

   function automatic xy_pkg::agen_req_s rq(logic [13:0] b, o,
         xy_pkg::addr_mode_e m, logic [13:0] st);
      rq = '{1'b1, b, o, m, st, st + 14'h000F};
   endfunction

   // One write, then the landing flag.
   task automatic wr1(logic [13:0] b, o, xy_pkg::addr_mode_e m,
         logic [15:0] d);
      logic [13:0] a;
      a = eff(rq(b, o, m, 14'h0100), 1'b1);
      EXU.issue(z, z, rq(b, o, m, 14'h0100), d, 1'b0);
      mem[a] = d;
      `CHK(in_y, a >= SPL)
   endtask

   // One read cycle on X and or Y with its answers.
   task automatic rd2(xy_pkg::agen_req_s x, y, logic m, bit yok);
      EXU.issue(x, y, z, 16'h0000, m);
      `CHK(xa.valid, x.valid)
      if (x.valid) `CHK(xa.data, mem[eff(x, 1'b0)])
      `CHK(ya.valid, yok)
      `CHK(refused, y.valid & ~yok)
      if (yok) `CHK(ya.data, mem[eff(y, 1'b0)])
   endtask

   task automatic tally_and_finish;
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Hang guard; the run needs about 190 cycles.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_count++;
         tally_and_finish;
      end
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      z = '0;
      void'($urandom(92));
      repeat (3) @(posedge clk);
      #1 resetn = 1'b1;
      @(posedge clk);
      #1;
      for (int i = 0; i < 30; i++) begin
         a0 = 14'($urandom_range(SPL - 1));
         a1 = SPL + 14'($urandom_range(14'h3FFF - SPL));
         wr1(a0, 14'h0000, xy_pkg::AM_LINEAR, 16'($urandom));
         wr1(a1, 14'h0000, xy_pkg::AM_LINEAR, 16'($urandom));
         rd2(rq(a1, 14'h0000, xy_pkg::AM_LINEAR, 14'h0), z, 1'b0, 0);
         rd2(rq(a0, 14'h0000, xy_pkg::AM_LINEAR, 14'h0),
             rq(a1, 14'h0000, xy_pkg::AM_LINEAR, 14'h0), 1'b1, 1);
         rd2(z, rq(a1, 14'h0000, xy_pkg::AM_LINEAR, 14'h0), 1'b0, 0);
         rd2(z, rq(a0, 14'h0000, xy_pkg::AM_LINEAR, 14'h0), 1'b1, 0);
      end
      wr1(14'h0102, 14'h0000, xy_pkg::AM_LINEAR, 16'hA5A5);
      wr1(14'h2102, 14'h0000, xy_pkg::AM_LINEAR, 16'h5A5A);
      rd2(rq(14'h010C, 14'h0006, xy_pkg::AM_MODULO, 14'h0100),
          rq(14'h210C, 14'h0006, xy_pkg::AM_MODULO, 14'h2100), 1'b1, 1);
      wr1(14'h0000, 14'h0002, xy_pkg::AM_BITREV, 16'hC3C3);
      rd2(rq(14'h0FFE, 14'h0002, xy_pkg::AM_BITREV, 14'h0), z, 1'b0, 0);
      // Full build wraps 1FF8+10 back to 1FF8 in X; reduced lands at 2008.
      EXU.issue(z, z, rq(14'h1FF8, 14'h0010, xy_pkg::AM_MODULO, 14'h1FF0),
                16'h3C3C, 1'b0);
      mem[14'h1FF8] = 16'h3C3C;
      `CHK(in_y, 1'b0)
      `CHK(lin_y, 1'b1)
      rd2(rq(14'h1FF8, 14'h0010, xy_pkg::AM_MODULO, 14'h1FF0),
          rq(14'h1FF8, 14'h0010, xy_pkg::AM_MODULO, 14'h1FF0), 1'b1, 0);
      `CHK(lxa.valid, 1'b1)
      `CHK(lxa.data, 16'h3C3C)
      `CHK(lya.valid, 1'b1)
      `CHK(lya.data, 16'h3C3C)
      `CHK(lrefused, 1'b0)
      EXU.issue(z, z, z, 16'h0000, 1'b0);
      tally_and_finish;
   end
endmodule
